//--- pkg/cims_map.vh
// Constants for the processor interface mode-select front end.
// Assumes inclusion by the single design file; definitions only.
`ifndef CIMS_MAP_VH
`define CIMS_MAP_VH
`define CIMS_ID_W        6
`define CIMS_ID_RST      6'h00
`define CIMS_BIT_LINE1   1
`define CIMS_BIT_LINE2   2
`define CIMS_BIT_LINE3   3
`define CIMS_PH_FULL     3'h4
`define CIMS_PH_THREE    3'h3
`define CIMS_PH_TWO      3'h2
`define CIMS_PH_ONE      3'h1
`define CIMS_CNT_W       8
`define CIMS_CNT_RST     8'h00
`define CIMS_PER_RST     8'h3F
`define CIMS_FIX_RST     2'h0
`endif

//--- rtl/cims_top.v
// Mode select, identification code capture and phase control front end.
// Assumes asynchronous pins (enable, id lines, phase straps) and an
// external analog loop that consumes the reference code and phase gates.
`timescale 1ns/1ps
`include "cims_map.vh"

// Contract
// - On enable rising edge, id line 1 high picks parallel, low picks serial.
// - Parallel mode uses all six id lines as the core reference code.
// - Parallel mode keeps the uncore plane in high impedance, no activity.
// - Serial mode ignores lines 0,4,5; lines 2,3 form the serial bus.
// - Parallel mode samples the code continuously, updating on each change.
// - Fixed mode uses bus lines as static select of 4 voltages, no commands.
// - Low-power flag from serial bus reduces the number of active phases.
// - One uncore phase and two to four interleaved core phases, cut to one under low power in serial mode outside fixed mode.
// - Enabled uncore phase is offset in timing from the core phases.
// - Phase 4 strapped low gives 3 phases; phases 3 and 4 low give 2.
// - High impedance pulls driver enable low; enabling releases it high.
// - Serial bus is one master to this slave, fast-mode two-wire signalling.
module cims_top #(
    parameter PERIOD_W = `CIMS_CNT_W   // phase carrier counter width
) (
    input  wire                   clk_i,          // 125 MHz clock
    input  wire                   srst_i,         // sync reset, active high
    input  wire                   enable_i,       // regulator enable pin
    input  wire [`CIMS_ID_W-1:0]  id_lines_i,     // id lines 0..5 (async)
    input  wire                   fix_mode_i,     // fixed-voltage debug strap
    input  wire                   low_power_state_flag_i, // from bus decoder
    input  wire                   phase3_strap_low_i, // phase 3 tied to ground
    input  wire                   phase4_strap_low_i, // phase 4 tied to ground
    input  wire [PERIOD_W-1:0]    period_i,       // carrier period in cycles
    output reg                    parallel_id_mode_o, // 1 parallel, 0 serial
    output reg  [`CIMS_ID_W-1:0]  core_ref_code_o,    // core reference code
    output reg                    core_ref_update_o,  // pulse on new code
    output reg  [1:0]             fixed_sel_o,        // fixed voltage select
    output reg                    fixed_active_o,     // fixed mode in force
    output wire                   serial_bus_clock_line_o, // to bus decoder
    output wire                   serial_bus_data_line_o,  // to bus decoder
    output reg                    serial_cmd_enable_o,     // decoder may act
    output reg  [2:0]             core_phase_count_o,      // active phases
    output reg  [3:0]             core_phase_outputs_o,    // phase gates
    output reg  [3:0]             core_phase_oe_o,         // 0 = floating
    output reg                    uncore_phase_output_o,   // uncore gate
    output reg                    uncore_phase_oe_o,       // 0 = floating
    output wire                   core_driver_enable_o,    // open drain out
    output wire                   core_driver_enable_oe_o, // high pulls low
    output wire                   uncore_driver_enable_o,  // open drain out
    output wire                   uncore_driver_enable_oe_o // high pulls low
);

// Three-stage synchroniser; stage 1 is read only by stage 2.
// The debug strap is a pin as well, so it rides the same synchroniser.
localparam SYNC_W = `CIMS_ID_W + 4;
reg  [SYNC_W-1:0] s1_r;
reg  [SYNC_W-1:0] s2_r;
reg  [SYNC_W-1:0] s3_r;
reg  [SYNC_W-1:0] stable_r;
wire [SYNC_W-1:0] raw_w = {fix_mode_i, phase4_strap_low_i,
                           phase3_strap_low_i, enable_i, id_lines_i};
wire [SYNC_W-1:0] agree_w = ~(s2_r ^ s3_r);
integer k;

always @(posedge clk_i) begin
    if (srst_i) begin
        s1_r     <= {SYNC_W{1'b0}};
        s2_r     <= {SYNC_W{1'b0}};
        s3_r     <= {SYNC_W{1'b0}};
        stable_r <= {SYNC_W{1'b0}};
    end else begin
        s1_r <= raw_w;
        s2_r <= s1_r;
        s3_r <= s2_r;
        for (k = 0; k < SYNC_W; k = k + 1) begin
            if (agree_w[k]) begin
                stable_r[k] <= s3_r[k];
            end
        end
    end
end

wire [`CIMS_ID_W-1:0] id_w    = stable_r[`CIMS_ID_W-1:0];
wire                  en_w    = stable_r[`CIMS_ID_W];
wire                  ph3lo_w = stable_r[`CIMS_ID_W+1];
wire                  ph4lo_w = stable_r[`CIMS_ID_W+2];
wire                  fix_w   = stable_r[`CIMS_ID_W+3];
reg                   en_d_r;
wire                  en_rise_w = en_w & ~en_d_r;

// Serial bus lines pass straight through once synchronised.
assign serial_bus_clock_line_o = id_w[`CIMS_BIT_LINE2];
assign serial_bus_data_line_o  = id_w[`CIMS_BIT_LINE3];

// Strap-derived phase count; captured with the mode at enable.
function [2:0] strap_count;
    input p3;
    input p4;
    begin
        if (p3 && p4) begin
            strap_count = `CIMS_PH_TWO;
        end else if (p4) begin
            strap_count = `CIMS_PH_THREE;
        end else begin
            strap_count = `CIMS_PH_FULL;
        end
    end
endfunction

reg [2:0] strap_ph_r;
reg       running_r;

always @(posedge clk_i) begin
    if (srst_i) begin
        en_d_r              <= 1'b0;
        running_r           <= 1'b0;
        parallel_id_mode_o  <= 1'b0;
        strap_ph_r          <= `CIMS_PH_FULL;
        core_ref_code_o     <= `CIMS_ID_RST;
        core_ref_update_o   <= 1'b0;
        fixed_sel_o         <= `CIMS_FIX_RST;
        fixed_active_o      <= 1'b0;
        serial_cmd_enable_o <= 1'b0;
    end else begin
        en_d_r            <= en_w;
        running_r         <= en_w;
        core_ref_update_o <= 1'b0;
        if (en_rise_w) begin
            // Mode holds until the next rising edge of enable.
            parallel_id_mode_o <= id_w[`CIMS_BIT_LINE1];
            strap_ph_r <= strap_count(ph3lo_w, ph4lo_w);
            fixed_active_o <= fix_w & ~id_w[`CIMS_BIT_LINE1];
        end
        if (en_w && parallel_id_mode_o && !en_rise_w &&
            id_w != core_ref_code_o) begin
            core_ref_code_o   <= id_w;
            core_ref_update_o <= 1'b1;
        end else if (en_rise_w && id_w[`CIMS_BIT_LINE1]) begin
            core_ref_code_o   <= id_w;
            core_ref_update_o <= 1'b1;
        end
        if (fixed_active_o && !parallel_id_mode_o) begin
            // Static select from the two bus lines.
            fixed_sel_o <= {id_w[`CIMS_BIT_LINE3],
                            id_w[`CIMS_BIT_LINE2]};
        end
        // Held low at the enable edge, while the new mode is still loading.
        serial_cmd_enable_o <= en_w & ~en_rise_w & ~parallel_id_mode_o
                               & ~fixed_active_o;
    end
end

// Active core phase count, cut to one under low power in serial mode outside fixed mode.
always @(posedge clk_i) begin
    if (srst_i) begin
        core_phase_count_o <= `CIMS_PH_FULL;
    end else if (!parallel_id_mode_o && low_power_state_flag_i &&
                 !fixed_active_o) begin
        core_phase_count_o <= `CIMS_PH_ONE;
    end else begin
        core_phase_count_o <= strap_ph_r;
    end
end

// Carrier counter; each active core phase starts at count*i/n, the
// uncore phase sits half a slot later to spread the input ripple.
reg [PERIOD_W-1:0] cnt_r;
reg [PERIOD_W-1:0] slot_r;
wire [PERIOD_W-1:0] per_w = (period_i == {PERIOD_W{1'b0}}) ?
                            `CIMS_PER_RST : period_i;

// Wraps at per_w minus one, so one carrier lasts exactly per_w cycles.
always @(posedge clk_i) begin
    if (srst_i || cnt_r >= per_w - {{(PERIOD_W-1){1'b0}}, 1'b1}) begin
        cnt_r <= `CIMS_CNT_RST;
    end else begin
        cnt_r <= cnt_r + {{(PERIOD_W-1){1'b0}}, 1'b1};
    end
end

always @* begin
    case (core_phase_count_o)
        `CIMS_PH_ONE:   slot_r = per_w;
        `CIMS_PH_TWO:   slot_r = per_w >> 1;
        `CIMS_PH_THREE: slot_r = per_w / `CIMS_PH_THREE;
        default:        slot_r = per_w >> 2;
    endcase
end

wire       uncore_on_w = running_r & ~parallel_id_mode_o;
wire [PERIOD_W-1:0] half_w = slot_r >> 1;
integer j;

always @(posedge clk_i) begin
    if (srst_i) begin
        core_phase_outputs_o  <= 4'h0;
        core_phase_oe_o       <= 4'h0;
        uncore_phase_output_o <= 1'b0;
        uncore_phase_oe_o     <= 1'b0;
    end else begin
        for (j = 0; j < 4; j = j + 1) begin
            // Each active phase is high for its own slot only.
            core_phase_oe_o[j] <= running_r && (j < core_phase_count_o);
            core_phase_outputs_o[j] <= running_r &&
                (j < core_phase_count_o) &&
                (cnt_r >= slot_r * j) &&
                (cnt_r <  slot_r * (j + 1));
        end
        uncore_phase_oe_o     <= uncore_on_w;
        uncore_phase_output_o <= uncore_on_w &&
            (cnt_r >= half_w) && (cnt_r < half_w + slot_r);
    end
end

// Open-drain enables: pulled low for high impedance, released to enable.
assign core_driver_enable_o      = 1'b0;
assign core_driver_enable_oe_o   = ~running_r;
assign uncore_driver_enable_o    = 1'b0;
assign uncore_driver_enable_oe_o = ~uncore_on_w;

endmodule // cims_top

//--- tb/cims_monitor.sv
// Checker for the mode-select front end, bound to cims_top by the bench.
// Assumes enable stays low while reset is held.
`timescale 1ns/1ps
module cims_monitor (
    input wire       clk_i,                    // clock
    input wire       srst_i,                   // reset
    input wire       enable_i,                 // enable pin
    input wire [5:0] id_lines_i,               // id lines
    input wire       low_power_state_flag_i,   // low power
    input wire       parallel_id_mode_o,       // mode
    input wire [5:0] core_ref_code_o,          // code
    input wire       core_ref_update_o,        // pulse
    input wire       fixed_active_o,           // fixed
    input wire       serial_bus_clock_line_o,  // bus clock
    input wire       serial_bus_data_line_o,   // bus data
    input wire       serial_cmd_enable_o,      // commands on
    input wire [2:0] core_phase_count_o,       // phases
    input wire       uncore_phase_oe_o,        // uncore oe
    input wire       uncore_driver_enable_oe_o // pulled low
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // A mode change needs a fresh enable rise a few cycles back.
    mode_on_edge_a: assert property ($changed(parallel_id_mode_o) |->
        enable_i && (!$past(enable_i, 6) || !$past(enable_i, 7)))
        else $error("mode moved without an enable edge");
    uncore_hiz_a: assert property (parallel_id_mode_o[*3] |->
        !uncore_phase_oe_o && uncore_driver_enable_oe_o)
        else $error("uncore plane active in parallel mode");
    ref_track_a: assert property ((parallel_id_mode_o && enable_i &&
        $stable(id_lines_i))[*7] |-> core_ref_code_o == id_lines_i)
        else $error("core code does not follow id lines");
    upd_pulse_a: assert property ($changed(core_ref_code_o) |->
        core_ref_update_o) else $error("code load without pulse");
    bus_follow_a: assert property ((!parallel_id_mode_o &&
        $stable(id_lines_i[3:2]))[*6] |-> {serial_bus_data_line_o,
        serial_bus_clock_line_o} == id_lines_i[3:2])
        else $error("serial bus lines do not follow");
    low_power_a: assert property ((low_power_state_flag_i &&
        !parallel_id_mode_o && !fixed_active_o)[*3] |->
        core_phase_count_o == 3'h1) else $error("low power not applied");
    fixed_serial_a: assert property (fixed_active_o |->
        !parallel_id_mode_o && !serial_cmd_enable_o)
        else $error("fixed mode with commands or parallel");
    phase_range_a: assert property (parallel_id_mode_o[*2] |->
        core_phase_count_o >= 3'h2 && core_phase_count_o <= 3'h4)
        else $error("core phase count out of range");
    cover property ($rose(parallel_id_mode_o));
    cover property ($rose(fixed_active_o));
    cover property (core_ref_update_o && parallel_id_mode_o);
endmodule // cims_monitor

//--- tb/cims_host.sv
// Host processor model: drives the id lines and the enable pin.
// Assumes the bench sets wanted levels; pins move at falling edges.
`timescale 1ns/1ps
module cims_host (
    input  wire       clk_i,      // bench clock
    input  wire [5:0] code_i,     // wanted id levels
    input  wire       en_i,       // wanted enable
    input  wire       frame_i,    // serial frame on
    output reg  [5:0] id_lines_o, // id lines 0..5
    output reg        enable_o    // enable pin
);
    reg sclk_r = 1'b1;
    initial begin
        id_lines_o = 6'h00;
        enable_o = 1'b0;
    end
    // The bus clock idles high between frames, as its pull-up would hold it.
    always #80 sclk_r = frame_i ? ~sclk_r : 1'b1;
    // Lines move on the same edge as enable, so the bench must settle line 1 first.
    always @(negedge clk_i) begin
        id_lines_o <= {code_i[5:3], frame_i ? sclk_r : code_i[2],
                       code_i[1:0]};
        enable_o <= en_i;
    end
endmodule // cims_host

//--- tb/tb_cims_top.sv
// Directed bench for the mode-select front end with host model and checker.
// Assumes cims_top, cims_host and cims_monitor are compiled before it.
`timescale 1ns/1ps
module tb_cims_top;
    reg        clk_i = 1'b0;
    reg        srst_i = 1'b1;
    reg  [5:0] code = 6'h00;
    reg        en = 1'b0;
    reg        frame = 1'b0;
    reg        fix = 1'b0;
    reg        lp = 1'b0;
    reg        s3 = 1'b0;
    reg        s4 = 1'b0;
    wire [5:0] id_w;
    wire [5:0] ref_o;
    wire [1:0] fsel_o;
    wire [2:0] cnt_o;
    wire       en_w, par_o, upd_o, fixa_o, sbc_o, sbd_o, cmd_o, uoe_o, udoe_o;
    wire [3:0] cpo_o, coe_o;
    wire       upo_o, cdoe_o;
    reg  [7:0] lag;
    integer    err_count = 0;
    integer    compares = 0;
    initial forever #4 clk_i = ~clk_i;
    cims_host i_host (.clk_i(clk_i), .code_i(code), .en_i(en),
        .frame_i(frame), .id_lines_o(id_w), .enable_o(en_w));
    cims_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .enable_i(en_w),
        .id_lines_i(id_w), .fix_mode_i(fix), .low_power_state_flag_i(lp),
        .phase3_strap_low_i(s3), .phase4_strap_low_i(s4), .period_i(8'h10),
        .parallel_id_mode_o(par_o), .core_ref_code_o(ref_o),
        .core_ref_update_o(upd_o), .fixed_sel_o(fsel_o),
        .fixed_active_o(fixa_o), .serial_bus_clock_line_o(sbc_o),
        .serial_bus_data_line_o(sbd_o), .serial_cmd_enable_o(cmd_o),
        .core_phase_count_o(cnt_o), .core_phase_outputs_o(cpo_o),
        .core_phase_oe_o(coe_o), .uncore_phase_output_o(upo_o),
        .uncore_phase_oe_o(uoe_o), .core_driver_enable_o(),
        .core_driver_enable_oe_o(cdoe_o), .uncore_driver_enable_o(),
        .uncore_driver_enable_oe_o(udoe_o));
    task report_and_stop;
        begin
            if (err_count == 0 && compares > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("wrong value at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task idle(input integer n);
        repeat (n) @(negedge clk_i);
    endtask
    // Lines and straps settle before enable rises, then the mode is taken.
    task power_up(input [5:0] c, input p3, input p4, input f);
        begin
            en <= 1'b0;
            code <= c;
            s3 <= p3;
            s4 <= p4;
            fix <= f;
            idle(6);
            en <= 1'b1;
            idle(12);
        end
    endtask
    // Cycles from the rise of core phase 1 to the rise of the uncore gate;
    // a missing edge leaves 8'hFF or the bound, so the compare fails.
    task phase_lag(output [7:0] lg);
        integer n;
        reg     prev;
        reg     seen;
        begin
            lg   = 8'hFF;
            seen = 1'b0;
            prev = cpo_o[0];
            for (n = 0; n < 64 && !seen; n = n + 1) begin
                @(negedge clk_i);
                seen = cpo_o[0] & ~prev;
                prev = cpo_o[0];
            end
            for (n = 0; n < 64 && seen && !upo_o; n = n + 1) begin
                @(negedge clk_i);
                lg = 8'(n + 1);
            end
        end
    endtask
    initial begin
        idle(8);
        srst_i <= 1'b0;
        power_up(6'h2A, 1'b0, 1'b0, 1'b0);
        chk(8'(par_o), 8'h01);
        chk(8'(ref_o), 8'h2A);
        chk(8'(cnt_o), 8'h04);
        chk(8'({uoe_o, udoe_o}), 8'h01);
        chk(8'({coe_o, cdoe_o}), 8'h1E);
        code <= 6'h15;
        idle(10);
        chk(8'(ref_o), 8'h15);
        chk(8'(par_o), 8'h01);
        power_up(6'h31, 1'b0, 1'b1, 1'b0);
        chk(8'(par_o), 8'h00);
        chk(8'(cnt_o), 8'h03);
        chk(8'(cmd_o), 8'h01);
        chk(8'({uoe_o, udoe_o}), 8'h02);
        code <= 6'h08;
        idle(10);
        chk(8'({sbd_o, sbc_o}), 8'h02);
        frame <= 1'b1;
        idle(60);
        frame <= 1'b0;
        lp <= 1'b1;
        idle(8);
        chk(8'(cnt_o), 8'h01);
        lp <= 1'b0;
        idle(8);
        chk(8'(cnt_o), 8'h03);
        chk(8'(coe_o), 8'h07);
        phase_lag(lag);
        chk(lag, 8'h02);
        power_up(6'h04, 1'b1, 1'b1, 1'b1);
        chk(8'(cnt_o), 8'h02);
        chk(8'({fixa_o, fsel_o}), 8'h05);
        chk(8'(cmd_o), 8'h00);
        report_and_stop;
    end
    initial begin
        #200000;
        err_count = err_count + 1;
        report_and_stop;
    end
endmodule // tb_cims_top
bind cims_top cims_monitor i_mon (.clk_i, .srst_i, .enable_i, .id_lines_i,
    .low_power_state_flag_i, .parallel_id_mode_o, .core_ref_code_o,
    .core_ref_update_o, .fixed_active_o, .serial_bus_clock_line_o,
    .serial_bus_data_line_o, .serial_cmd_enable_o, .core_phase_count_o,
    .uncore_phase_oe_o, .uncore_driver_enable_oe_o);
